// [tcs_pkg.sv]
// constants, types and code tables for the teleprinter call sequencer
package tcs_pkg;
   // ==============================================================
   // clock and timing
   localparam longint TCS_CLK_PERIOD_NS  = 8;
   localparam longint TCS_CLK_HZ         = 125_000_000;
   localparam longint TCS_ACK_MAX_MS     = 40_000;   // exchange ack limit
   localparam longint TCS_SPACE_HOLD_MS  = 1_000;    // open line clear
   localparam longint TCS_MARK_HOLD_MS   = 5_000;    // closed line clear
   localparam longint TCS_ACK_MAX_CYCLES =
      TCS_ACK_MAX_MS * (TCS_CLK_HZ / 1000);          // longest: round down
   localparam longint TCS_SPACE_CYCLES   =
      TCS_SPACE_HOLD_MS * (TCS_CLK_HZ / 1000);
   localparam longint TCS_MARK_CYCLES    =
      TCS_MARK_HOLD_MS * (TCS_CLK_HZ / 1000);
   // bit times in ns: 50, 45.45 and 110 bits per second
   localparam longint TCS_BIT_EXCH_NS    = 20_000_000;
   localparam longint TCS_BIT_60WPM_NS   = 22_000_000;
   localparam longint TCS_BIT_100WPM_NS  = 9_090_910;
   localparam longint TCS_BIT_EXCH_CYC   =
      TCS_BIT_EXCH_NS / TCS_CLK_PERIOD_NS;
   localparam longint TCS_BIT_60WPM_CYC  =
      TCS_BIT_60WPM_NS / TCS_CLK_PERIOD_NS;
   localparam longint TCS_BIT_100WPM_CYC =
      TCS_BIT_100WPM_NS / TCS_CLK_PERIOD_NS;
   // ==============================================================
   // characters and counts
   localparam logic [6:0] TCS_FIGURES_SHIFT = 7'h1B;
   localparam logic [6:0] TCS_LETTERS_SHIFT = 7'h1F;
   localparam logic [6:0] TCS_ANSWER_BACK   = 7'h1E;
   localparam logic [6:0] TCS_NULL_CHAR     = 7'h00;
   localparam logic [2:0] TCS_OPEN_LINE_NULLS = 3'h5;
   localparam logic [3:0] TCS_SLOW_BUF_LIMIT  = 4'hC;
   localparam logic [3:0] TCS_FIVE_LEVEL_BITS = 4'h5;
   localparam logic [3:0] TCS_ASCII_BITS      = 4'h7;
   localparam logic [4:0] TCS_DIGIT_CODE [0:9] = '{
      5'h16, 5'h17, 5'h13, 5'h01, 5'h0A,
      5'h10, 5'h15, 5'h07, 5'h06, 5'h18};
   // ascii characters a slow station cannot print
   localparam logic [6:0] TCS_UNPRINTABLE [0:8] = '{
      7'h25, 7'h40, 7'h26, 7'h5E, 7'h5F, 7'h23, 7'h3D, 7'h2B, 7'h22};
   // ==============================================================
   // station arrangements
   typedef enum logic [1:0] {
      TCS_MODE_EXCH   = 2'b00,
      TCS_MODE_60WPM  = 2'b01,
      TCS_MODE_100WPM = 2'b10
   } tcs_mode_t;
   // sequencer states
   typedef enum logic [3:0] {
      TCS_IDLE     = 4'b0000,
      TCS_FIGURES_SHIFT_CHAR     = 4'b0001,
      TCS_DIG_WAIT = 4'b0010,
      TCS_DIG_SEND = 4'b0011,
      TCS_ACK_WAIT = 4'b0100,
      TCS_EOS_SEND = 4'b0101,
      TCS_ANS_WAIT = 4'b0110,
      TCS_CONN     = 4'b0111,
      TCS_CLEAR    = 4'b1000,
      TCS_INCOMING = 4'b1001
   } tcs_state_t;
endpackage

// [tcs_serial_port.sv]
// start-stop character transmitter and receiver for the exchange line
`timescale 1ns/1ns
`default_nettype none
module tcs_serial_port
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic [31:0] bit_cycles,
   input  wire logic [3:0]  char_bits,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   input  wire logic [6:0]  tx_char,
   input  wire logic        force_en,
   input  wire logic        force_level,
   output logic             line_out,
   input  wire logic        line_in,
   output logic             rx_valid,
   output logic [6:0]       rx_char
);
   // ==============================================================
   // transmitter: start bit, data lsb first, one stop bit
   logic [31:0] tx_cnt;
   logic [3:0]  tx_bits;
   logic [8:0]  tx_shift;
   logic        tx_busy;
   wire         tx_bit_end = (tx_cnt == bit_cycles - 32'h1);
   wire         tx_take    = tx_valid && tx_ready;
   assign tx_ready = !tx_busy && !force_en;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tx_busy  <= 1'b0;
         tx_cnt   <= 32'h0;
         tx_bits  <= 4'h0;
         tx_shift <= 9'h1FF;
         line_out <= 1'b1;
      end
      else if (tx_take)
      begin
         tx_busy  <= 1'b1;
         tx_cnt   <= 32'h0;
         tx_bits  <= char_bits + 4'h1;  // data plus stop
         tx_shift <= {1'b1, tx_char, 1'b0};
         line_out <= 1'b0;              // start bit
      end
      else if (tx_busy && tx_bit_end)
      begin
         tx_cnt   <= 32'h0;
         tx_shift <= {1'b1, tx_shift[8:1]};
         line_out <= (tx_bits <= 4'h1) ? 1'b1 : tx_shift[1];  // no glitch
         tx_bits  <= tx_bits - 4'h1;
         if (tx_bits == 4'h0)
            tx_busy <= 1'b0;
      end
      else
      begin
         tx_cnt <= tx_busy ? tx_cnt + 32'h1 : 32'h0;
         if (!tx_busy)
            line_out <= force_en ? force_level : 1'b1;
      end
   end

   // ==============================================================
   // receiver: mid-bit sampling; a broken stop bit still yields the
   // character so that an open line reads as a run of nulls
   logic [31:0] rx_cnt;
   logic [3:0]  rx_bits;
   logic [6:0]  rx_shift;
   logic        rx_busy;
   wire         rx_half = (rx_cnt == {1'b0, bit_cycles[31:1]});
   wire         rx_full = (rx_cnt == bit_cycles - 32'h1);

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rx_busy  <= 1'b0;
         rx_cnt   <= 32'h0;
         rx_bits  <= 4'h0;
         rx_shift <= 7'h00;
         rx_valid <= 1'b0;
         rx_char  <= 7'h00;
      end
      else
      begin
         rx_valid <= 1'b0;
         if (!rx_busy)
         begin
            rx_cnt <= 32'h0;
            if (!line_in)
               rx_busy <= 1'b1;
            rx_bits  <= 4'h0;
            rx_shift <= 7'h00;
         end
         else if (rx_bits == 4'h0)
         begin
            rx_cnt <= rx_half ? 32'h0 : rx_cnt + 32'h1;
            if (rx_half)
               rx_bits <= 4'h1;          // centre of start bit
         end
         else if (rx_full)
         begin
            rx_cnt  <= 32'h0;
            rx_bits <= rx_bits + 4'h1;
            if (rx_bits <= char_bits)
               rx_shift <= {line_in, rx_shift[6:1]};
            else
            begin
               rx_busy  <= 1'b0;       // stop bit slot
               rx_valid <= 1'b1;
               rx_char  <= rx_shift >> (4'h7 - char_bits);
            end
         end
         else
            rx_cnt <= rx_cnt + 32'h1;
      end
   end
endmodule
`default_nettype wire

// [tcs_call_sequencer.sv]
// call-control sequencer: dialing, answer, clearing and station rules
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RQ1 - each dial digit goes out as its fixed five-level code
// RQ2 - a figures-shift character precedes the first dial digit
// RQ3 - exchange digits and characters are serialised at 50 bits/s
// RQ4 - one digit at a time, each waits for its acknowledgement
// RQ5 - exchange acknowledges with letters-shift between 300 ms and 40 s
// RQ6 - after the last acknowledged digit, send the configured end code
// RQ7 - answer-back 1E or 1F means the outgoing call reached its target
// RQ8 - five received nulls (open line) mean refused digit or busy
// RQ9 - clearing holds line open 1 s or closed 5 to 40 s
// RQ10 - open line while connected means the far end cleared
// RQ11 - armed receiver takes 1E or 1F as incoming call established; code takes any non-null character
// RQ12 - no indication at off-hook; arriving data is first sign
// RQ13 - incoming call stays up until the caller hangs up
// RQ14 - 60 wpm station: five-level code at 45.45 bits/s
// RQ15 - 100 wpm station: seven-bit ascii at 110 bits/s
// RQ16 - to slow stations, buffers above 12 characters are flagged
// RQ17 - unprintable characters to slow stations are dropped
// RQ18 - missing acknowledgement within 40 s abandons dialing
module tcs_call_sequencer
#(
   parameter logic [32:0] ACK_CYCLES   = 33'(tcs_pkg::TCS_ACK_MAX_CYCLES),
   parameter logic [32:0] SPACE_CYCLES = 33'(tcs_pkg::TCS_SPACE_CYCLES),
   parameter logic [32:0] MARK_CYCLES  = 33'(tcs_pkg::TCS_MARK_CYCLES),
   parameter logic [31:0] BIT_EXCH     = 32'(tcs_pkg::TCS_BIT_EXCH_CYC),
   parameter logic [31:0] BIT_60WPM    = 32'(tcs_pkg::TCS_BIT_60WPM_CYC),
   parameter logic [31:0] BIT_100WPM   = 32'(tcs_pkg::TCS_BIT_100WPM_CYC)
)
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic [1:0]  station_mode,
   input  wire logic        slow_dest,
   input  wire logic [4:0]  eos_code,
   input  wire logic        dial_start,
   input  wire logic        digit_valid,
   output logic             digit_ready,
   input  wire logic [3:0]  digit_value,
   input  wire logic        digit_last,
   input  wire logic        answer_arm,
   input  wire logic        clear_request,
   input  wire logic        clear_closed_line_level,
   input  wire logic        msg_valid,
   output logic             msg_ready,
   input  wire logic [6:0]  msg_char,
   input  wire logic        msg_last,
   output logic             rx_out_valid,
   output logic [6:0]       rx_out_char,
   output logic             call_up,
   output logic             call_incoming,
   output logic             dial_failed,
   output logic             call_failed,
   output logic             call_cleared,
   output logic             char_dropped,
   output logic             buf_over_limit,
   output logic             line_out,
   input  wire logic        line_in
);
   // ==============================================================
   // declarations
   tcs_pkg::tcs_state_t state;
   tcs_pkg::tcs_state_t next_state;
   logic [32:0] timer;
   logic [2:0]  null_run;
   logic [3:0]  buf_count;
   logic [4:0]  digit_code;
   logic        digit_is_last;
   logic        tx_ready;
   logic        rx_valid;
   logic [6:0]  rx_char;

   // ==============================================================
   // station arrangement: rate and character width
   wire mode_60  = (station_mode == tcs_pkg::TCS_MODE_60WPM);
   wire mode_100 = (station_mode == tcs_pkg::TCS_MODE_100WPM);
   wire [31:0] bit_cycles = mode_100 ? BIT_100WPM :          // [RQ15]
                            mode_60  ? BIT_60WPM  :          // [RQ14]
                                       BIT_EXCH;             // [RQ3]
   wire [3:0] char_bits = mode_100 ? tcs_pkg::TCS_ASCII_BITS
                                   : tcs_pkg::TCS_FIVE_LEVEL_BITS;

   // ==============================================================
   // received character classification
   wire rx_ack    = rx_valid && rx_char == tcs_pkg::TCS_LETTERS_SHIFT;
   wire rx_answer = rx_valid && (rx_char == tcs_pkg::TCS_ANSWER_BACK ||
                                 rx_char == tcs_pkg::TCS_LETTERS_SHIFT);
   wire rx_null   = rx_valid && rx_char == tcs_pkg::TCS_NULL_CHAR;
   // fifth null in a row: roughly 650 ms of open line at 50 bits/s
   wire open_line = rx_null &&
                    (null_run == tcs_pkg::TCS_OPEN_LINE_NULLS - 3'h1);
   wire ack_late  = (timer >= ACK_CYCLES - 33'h1);
   wire hold_done = clear_closed_line_level ? (timer >= MARK_CYCLES - 33'h1)
                                  : (timer >= SPACE_CYCLES - 33'h1);

   // ==============================================================
   // message path: slow-station filter and buffer length watch
   logic [8:0] bad_hit;
   genvar gi;
   generate
      for (gi = 0; gi < 9; gi++)
      begin : g_bad
         assign bad_hit[gi] = (msg_char == tcs_pkg::TCS_UNPRINTABLE[gi]);
      end
   endgenerate
   wire slow_ascii = slow_dest && mode_100;
   wire msg_drop   = slow_ascii && (|bad_hit);                // [RQ17]
   wire in_conn    = (state == tcs_pkg::TCS_CONN);
   assign msg_ready = in_conn && (tx_ready || msg_drop);
   wire msg_take   = msg_valid && msg_ready;

   // ==============================================================
   // transmit selection
   wire tx_from_seq = (state == tcs_pkg::TCS_FIGURES_SHIFT_CHAR) ||
                      (state == tcs_pkg::TCS_DIG_SEND) ||
                      (state == tcs_pkg::TCS_EOS_SEND);
   wire tx_valid = tx_from_seq || (in_conn && msg_valid && !msg_drop);
   wire [6:0] tx_char =
      (state == tcs_pkg::TCS_FIGURES_SHIFT_CHAR)     ? tcs_pkg::TCS_FIGURES_SHIFT : // [RQ2]
      (state == tcs_pkg::TCS_DIG_SEND) ? {2'b00, digit_code} :        // [RQ1]
      (state == tcs_pkg::TCS_EOS_SEND) ? {2'b00, eos_code} :          // [RQ6]
                                         msg_char;
   wire tx_take = tx_valid && tx_ready;
   wire force_en = (state == tcs_pkg::TCS_CLEAR);
   assign digit_ready = (state == tcs_pkg::TCS_DIG_WAIT);
   wire digit_take = digit_valid && digit_ready;

   // ==============================================================
   // sequencer next state
   always_comb
   begin
      next_state = state;
      unique case (state)
         tcs_pkg::TCS_IDLE:
            if (dial_start)
               next_state = tcs_pkg::TCS_FIGURES_SHIFT_CHAR;
            else if (answer_arm)
               next_state = tcs_pkg::TCS_INCOMING;
         tcs_pkg::TCS_FIGURES_SHIFT_CHAR:
            if (tx_take)
               next_state = tcs_pkg::TCS_DIG_WAIT;
         tcs_pkg::TCS_DIG_WAIT:
            if (digit_take)
               next_state = tcs_pkg::TCS_DIG_SEND;
         tcs_pkg::TCS_DIG_SEND:
            if (tx_take)
               next_state = tcs_pkg::TCS_ACK_WAIT;
         tcs_pkg::TCS_ACK_WAIT:                               // [RQ4]
            if (open_line)
               next_state = tcs_pkg::TCS_IDLE;                // [RQ8]
            else if (rx_ack)
               next_state = digit_is_last ? tcs_pkg::TCS_EOS_SEND
                                          : tcs_pkg::TCS_DIG_WAIT;
            else if (ack_late)
               next_state = tcs_pkg::TCS_IDLE;                // [RQ18]
         tcs_pkg::TCS_EOS_SEND:
            if (tx_take)
               next_state = tcs_pkg::TCS_ANS_WAIT;
         tcs_pkg::TCS_ANS_WAIT:
            if (rx_answer)
               next_state = tcs_pkg::TCS_CONN;                // [RQ7]
            else if (open_line || ack_late)
               next_state = tcs_pkg::TCS_IDLE;                // [RQ8]
         tcs_pkg::TCS_CONN:
            if (open_line)
               next_state = tcs_pkg::TCS_IDLE;                // [RQ10]
            // idle serialiser first, else the clear level is cut short
            else if (clear_request && !call_incoming &&       // [RQ13]
                     tx_ready && !tx_valid)
               next_state = tcs_pkg::TCS_CLEAR;
         tcs_pkg::TCS_CLEAR:
            if (hold_done)
               next_state = tcs_pkg::TCS_IDLE;                // [RQ9]
         tcs_pkg::TCS_INCOMING:
            // any arriving non-null data is the first sign of a call
            if (rx_valid && !rx_null)
               next_state = tcs_pkg::TCS_CONN;                // [RQ11] [RQ12]
            else if (!answer_arm)
               next_state = tcs_pkg::TCS_IDLE;
         default:
            next_state = tcs_pkg::TCS_IDLE;
      endcase
   end

   // ==============================================================
   // state, timer and digit latch
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state         <= tcs_pkg::TCS_IDLE;
         timer         <= 33'h0;
         digit_code    <= 5'h00;
         digit_is_last <= 1'b0;
      end
      else
      begin
         state <= next_state;
         timer <= (next_state != state) ? 33'h0 : timer + 33'h1;
         if (digit_take)
         begin
            digit_code    <= tcs_pkg::TCS_DIGIT_CODE[digit_value];  // [RQ1]
            digit_is_last <= digit_last;
         end
      end
   end

   // ==============================================================
   // null run counter, buffer length and receive forwarding
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         null_run       <= 3'h0;
         buf_count      <= 4'h0;
         buf_over_limit <= 1'b0;
         rx_out_valid   <= 1'b0;
         rx_out_char    <= 7'h00;
      end
      else
      begin
         if (rx_valid)
            null_run <= (rx_null && !open_line) ? null_run + 3'h1 : 3'h0;
         // advisory only: stalling here could deadlock a long buffer
         if (msg_take)
         begin
            buf_count <= msg_last ? 4'h0 : buf_count + 4'h1;
            if (!msg_last && slow_ascii &&
                buf_count == tcs_pkg::TCS_SLOW_BUF_LIMIT - 4'h1)
               buf_over_limit <= 1'b1;                        // [RQ16]
            else if (msg_last)
               buf_over_limit <= 1'b0;
         end
         rx_out_valid <= rx_valid && (in_conn ||
                         state == tcs_pkg::TCS_INCOMING);
         if (rx_valid)
            rx_out_char <= rx_char;
      end
   end

   // ==============================================================
   // call status reporting
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         call_up       <= 1'b0;
         call_incoming <= 1'b0;
         dial_failed   <= 1'b0;
         call_failed   <= 1'b0;
         call_cleared  <= 1'b0;
         char_dropped  <= 1'b0;
      end
      else
      begin
         call_up      <= (next_state == tcs_pkg::TCS_CONN);
         if (state == tcs_pkg::TCS_INCOMING &&
             next_state == tcs_pkg::TCS_CONN)
            call_incoming <= 1'b1;
         else if (next_state == tcs_pkg::TCS_IDLE)
            call_incoming <= 1'b0;
         dial_failed  <= (state == tcs_pkg::TCS_ACK_WAIT) && !open_line &&
                         !rx_ack && ack_late;                 // [RQ18]
         call_failed  <= ((state == tcs_pkg::TCS_ACK_WAIT ||
                           state == tcs_pkg::TCS_ANS_WAIT) && open_line) ||
                         (state == tcs_pkg::TCS_ANS_WAIT && !rx_answer &&
                          ack_late);                          // [RQ8]
         call_cleared <= (in_conn && open_line) ||            // [RQ10]
                         (state == tcs_pkg::TCS_CLEAR && hold_done);
         char_dropped <= msg_take && msg_drop;                // [RQ17]
      end
   end

   // ==============================================================
   // line serialiser
   tcs_serial_port u_port
   (
      .core_clk    (core_clk),
      .nrst        (nrst),
      .bit_cycles  (bit_cycles),
      .char_bits   (char_bits),
      .tx_valid    (tx_valid),
      .tx_ready    (tx_ready),
      .tx_char     (tx_char),
      .force_en    (force_en),
      .force_level (clear_closed_line_level),                           // [RQ9]
      .line_out    (line_out),
      .line_in     (line_in),
      .rx_valid    (rx_valid),
      .rx_char     (rx_char)
   );

   // ==============================================================
   // checks
   figures_shift_char_first_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ2]
      state == tcs_pkg::TCS_IDLE && dial_start
      |=> state == tcs_pkg::TCS_FIGURES_SHIFT_CHAR && tx_char == 7'h1B)
      else $error("figures shift not first");
   digit_code_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ1]
      digit_take && digit_value == 4'h2
      |=> tx_char == 7'h13)
      else $error("digit two wrong code");
   one_digit_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ4]
      state == tcs_pkg::TCS_ACK_WAIT && !rx_ack && !ack_late && !open_line
      |=> !digit_ready)
      else $error("digit taken before acknowledgement");
   ack_timeout_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ18]
      state == tcs_pkg::TCS_ACK_WAIT && ack_late && !rx_ack && !open_line
      |=> dial_failed && state == tcs_pkg::TCS_IDLE)
      else $error("ack timeout not reported");
   answer_up_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ7]
      state == tcs_pkg::TCS_ANS_WAIT && rx_answer
      |=> call_up)
      else $error("answer back did not raise call");
   open_clear_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ10]
      in_conn && open_line |=> call_cleared && !call_up)
      else $error("remote clear missed");
   incoming_hold_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ13]
      in_conn && call_incoming && !open_line |=> state != tcs_pkg::TCS_CLEAR)
      else $error("incoming call cleared locally");
   no_bad_char_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ17]
      in_conn && msg_drop |-> !tx_valid)
      else $error("unprintable character sent");
   clear_line_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ9]
      state == tcs_pkg::TCS_CLEAR && $past(state) == tcs_pkg::TCS_CLEAR
      && $past(state, 2) == tcs_pkg::TCS_CLEAR
      |-> line_out == clear_closed_line_level)
      else $error("clearing level not held");
   rate_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ3]
      station_mode == tcs_pkg::TCS_MODE_EXCH |-> bit_cycles == BIT_EXCH)
      else $error("exchange rate wrong");
endmodule
`default_nettype wire

// [tcs_xchg_model.sv]
// exchange-side model: captures device chars, sends replies
`timescale 1ns/1ns
`default_nettype none
module tcs_xchg_model
#(
   parameter int BIT = 16
)
(
   input  wire logic core_clk,
   input  wire logic line_out,
   output logic      line_in
);
   logic [4:0] got [$];
   logic [4:0] sh;
   // ========
   // capture
   // mid-bit sampling, lsb first, five data bits
   initial line_in = 1'b1;
   always
   begin
      @(negedge line_out);
      repeat (BIT / 2 + BIT) @(posedge core_clk);
      for (int i = 0; i < 5; i++)
      begin
         sh[i] = line_out;
         repeat (BIT) @(posedge core_clk);
      end
      got.push_back(sh);
   end
   // ========
   // reply
   // the gap stands for the minimum reply delay, scaled down
   task automatic send(input logic [4:0] c);
      repeat (40) @(negedge core_clk);
      line_in = 1'b0;
      repeat (BIT) @(negedge core_clk);
      for (int i = 0; i < 5; i++)
      begin
         line_in = c[i];
         repeat (BIT) @(negedge core_clk);
      end
      line_in = 1'b1;   // stop bit; return now so status pulses are seen
   endtask
endmodule
`default_nettype wire

// [teleprinter_call_sequencer_bench.sv]
// self-checking bench for the call sequencer
`timescale 1ns/1ns
`default_nettype none
module teleprinter_call_sequencer_bench;
   logic core_clk = 1'b0;
   logic nrst, dial_start, digit_valid, digit_last, answer_arm;
   logic clear_request, clear_closed_line_level, digit_ready, msg_ready;
   logic call_up, call_incoming, dial_failed, call_failed;
   logic call_cleared, line_out, line_in, rx_out_valid;
   logic [3:0] digit_value;
   logic [4:0] eos;
   logic [6:0] rx_out_char;
   logic [6:0] msg_char;
   logic [1:0] station_mode;
   logic       slow_dest, msg_valid, msg_last, char_dropped, buf_over_limit;
   int         n_rx = 0;
   int         err_total = 0;
   int         n_checks = 0;
   int         n;
   logic [4:0] code [0:9] = '{5'h16, 5'h17, 5'h13, 5'h01, 5'h0A,
                              5'h10, 5'h15, 5'h07, 5'h06, 5'h18};
   always #4 core_clk = ~core_clk;
   // counts forwarded characters; the pulse is too short to poll
   always @(posedge core_clk) n_rx <= n_rx + int'(rx_out_valid);
   tcs_call_sequencer #(.ACK_CYCLES(33'd2000), .SPACE_CYCLES(33'd300),
      .MARK_CYCLES(33'd500), .BIT_EXCH(32'd16), .BIT_60WPM(32'd16),
      .BIT_100WPM(32'd16)) dut
   (
      .core_clk, .nrst, .station_mode, .slow_dest,
      .eos_code(eos), .dial_start, .digit_valid, .digit_ready,
      .digit_value, .digit_last, .answer_arm, .clear_request,
      .clear_closed_line_level, .msg_valid, .msg_ready, .msg_char,
      .msg_last, .rx_out_valid, .rx_out_char, .call_up,
      .call_incoming, .dial_failed, .call_failed, .call_cleared,
      .char_dropped, .buf_over_limit, .line_out, .line_in
   );
   tcs_xchg_model xm
   (
      .core_clk, .line_out, .line_in
   );
   // ========
   // helpers
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic step();
      @(posedge core_clk);
      #1;
   endtask
   task automatic pulse_dial();
      xm.got.delete();
      @(negedge core_clk) dial_start = 1'b1;
      @(negedge core_clk) dial_start = 1'b0;
   endtask
   task automatic give_digit(input logic [3:0] v, input logic last);
      for (n = 0; n < 500 && digit_ready !== 1'b1; n++) step();
      @(negedge core_clk) {digit_valid, digit_value, digit_last} =
         {1'b1, v, last};
      @(negedge core_clk) digit_valid = 1'b0;
   endtask
   task automatic wait_chars(input int k);
      for (n = 0; n < 900 && xm.got.size() < k; n++) step();
   endtask
   // ========
   // scenarios
   task automatic dial_ok();
      pulse_dial();
      for (int d = 0; d < 10; d++)
      begin
         give_digit(4'(d), d == 9);
         wait_chars(d + 2);
         chk("ready in ack wait", 0, digit_ready);
         xm.send(5'h1F);
      end
      wait_chars(12);
      xm.send(5'h1E);
      for (n = 0; n < 900 && call_up !== 1'b1; n++) step();
      chk("call up", 1, call_up);
      chk("shift", 8'h1B, xm.got[0]);
      for (int d = 0; d < 10; d++) chk("digit", code[d], xm.got[d + 1]);
      chk("end code", 8'h08, xm.got[11]);
   endtask
   // open-line clear must last the whole hold
   task automatic clear_open();
      @(negedge core_clk) {clear_closed_line_level, clear_request} = 2'b01;
      @(negedge core_clk) clear_request = 1'b0;
      for (n = 0; n < 400 && call_cleared !== 1'b1; n++)
      begin
         step();
         if (n == 290) chk("open line", 0, line_out);
      end
      chk("cleared", 1, call_cleared);
      chk("hold long", 1, n >= 290);
   endtask
   task automatic ack_lost();
      pulse_dial();
      give_digit(4'h4, 1'b0);
      for (n = 0; n < 2600 && dial_failed !== 1'b1; n++) step();
      chk("dial failed", 1, dial_failed);
      chk("not early", 1, n >= 2000);
   endtask
   task automatic nulls();
      repeat (5) xm.send(5'h00);
   endtask
   task automatic open_line();
      pulse_dial();
      give_digit(4'h3, 1'b0);
      wait_chars(2);
      nulls();
      for (n = 0; n < 300 && call_failed !== 1'b1; n++) step();
      chk("call failed", 1, call_failed);
   endtask
   // slow station: unprintable chars eaten, long buffer flagged
   task automatic slow_msg();
      @(negedge core_clk) {station_mode, slow_dest, msg_valid} = 4'hB;
      msg_char = 7'h25;
      repeat (12) @(negedge core_clk) chk("drop", 1, char_dropped);
      chk("over limit", 1, buf_over_limit);
      msg_last = 1'b1;
      @(negedge core_clk) chk("limit reset", 0, buf_over_limit);
      {station_mode, slow_dest, msg_valid, msg_last} = '0;
   endtask
   task automatic incoming();
      @(negedge core_clk) answer_arm = 1'b1;
      repeat (20) step();
      chk("no early sign", 0, call_incoming);
      xm.send(5'h1F);
      for (n = 0; n < 300 && call_incoming !== 1'b1; n++) step();
      chk("incoming", 1, call_incoming);
      chk("rx char", 8'h1F, rx_out_char);
      @(negedge core_clk) clear_request = 1'b1;
      @(negedge core_clk) clear_request = 1'b0;
      repeat (400) step();
      chk("still up", 1, call_incoming);
      slow_msg();
      nulls();
      for (n = 0; n < 300 && call_cleared !== 1'b1; n++) step();
      chk("far clear", 1, call_cleared);
      @(negedge core_clk) answer_arm = 1'b0;
      step();
      chk("rx count", 6, n_rx);
   endtask
   // ========
   // run control
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog well past the expected run length
   initial
   begin
      repeat (30000) @(posedge core_clk);
      err_total++;
      complete_run();
   end
   initial
   begin
      {nrst, dial_start, digit_valid, digit_last, answer_arm} = '0;
      {clear_request, clear_closed_line_level, digit_value} = '0;
      {station_mode, slow_dest, msg_valid, msg_last, msg_char} = '0;
      eos = 5'h08;
      repeat (12) @(posedge core_clk);
      @(negedge core_clk) nrst = 1'b1;
      dial_ok();
      clear_open();
      ack_lost();
      open_line();
      incoming();
      complete_run();
   end
endmodule
`default_nettype wire
